/* rtl/hmb_top.v */
// Host mailbox pair, status pins and APB register file
//
// Notes on behaviour
// R1: A completed host write into the inbox raises the inbox full flag, which means full while high.
// R2: An internal processor read of the inbox clears the inbox full flag.
// R3: An internal processor write of the outbox sets the outbox full flag and holds it while unread.
// R4: A host read of the outbox returns the outbox full flag to zero.
// R5: Mailbox select high with read select low makes a host transfer a write into the inbox.
// R6: Mailbox select high with read select high makes a host transfer a read of the outbox.
// R7: Four external status inputs can be polled by the internal processor.
// R8: The status inputs also set their bits in the event register.
// R9: The four status outputs follow register bits that the internal processor sets or clears.
// R10: The status outputs also carry a pattern during the initialisation after reset.
// R11: Reset clears both full flags and drives the status outputs to a defined level.
// R12: The host writes only while the inbox is empty and reads only while the outbox is full; host_wr and host_rd here ignore both full flags.
`timescale 1ns/10ps
`include "hmb_defs.vh"
module hmb_top
(
    input  wire                   CORE_CLK_I,
    input  wire                   NRST_I,
    input  wire                   PSEL_I,
    input  wire                   PENABLE_I,
    input  wire                   PWRITE_I,
    input  wire [`HMB_ADDR_W-1:0] PADDR_I,
    input  wire [31:0]            PWDATA_I,
    output reg                    PREADY_O,
    output reg  [31:0]            PRDATA_O,
    output reg                    PSLVERR_O,
    input  wire                   MAILBOX_SELECT_I,
    input  wire                   HOST_PORT_READ_SELECT_I,
    input  wire                   HOST_STROBE_I,
    input  wire [31:0]            HOST_DATA_I,
    output reg  [31:0]            HOST_DATA_O,
    output reg                    HOST_DATA_OE_O,
    output reg                    INBOX_FULL_FLAG_O,
    output reg                    OUTBOX_FULL_FLAG_O,
    input  wire [3:0]             EXT_STATUS_IN_I,
    output reg  [3:0]             EXT_STATUS_OUT_O,
    output reg                    IRQ_O
);
    // ==========================================================
    // Reset and pin synchronisation
    wire                    rst_n;
    wire [`HMB_SYNC_W-1:0]  pins_sync;
    wire                    sel_s;
    wire                    rd_s;
    wire                    strobe_s;
    wire [31:0]             data_s;
    wire [3:0]              status_s;

    hmb_reset_sync u_rst
    (
        .clk_i   (CORE_CLK_I),
        .nrst_i  (NRST_I),
        .rst_n_o (rst_n)
    );

    hmb_sync #(.WIDTH(`HMB_SYNC_W)) u_sync
    (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_n),
        .async_i ({EXT_STATUS_IN_I, HOST_DATA_I, HOST_STROBE_I,
                   HOST_PORT_READ_SELECT_I, MAILBOX_SELECT_I}),
        .sync_o  (pins_sync)
    );

    assign sel_s    = pins_sync[0];
    assign rd_s     = pins_sync[1];
    assign strobe_s = pins_sync[2];
    assign data_s   = pins_sync[34:3];
    assign status_s = pins_sync[38:35];

    // ==========================================================
    // Host port transfer decode
    reg        strobe_d;
    reg  [3:0] status_d;
    wire       host_start;
    wire       host_wr;
    wire       host_rd;

    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_d <= 1'b0;
            status_d <= 4'h0;
        end
        else
        begin
            strobe_d <= strobe_s;
            status_d <= status_s;
        end
    end

    // A rising edge of the synced strobe starts one transfer
    assign host_start = strobe_s & ~strobe_d;
    assign host_wr    = host_start & sel_s & ~rd_s; // R5
    assign host_rd    = host_start & sel_s & rd_s;  // R6

    // ==========================================================
    // APB decode
    wire       apb_do;
    wire       apb_wr;
    wire       apb_rd;
    reg  [6:0] dec;
    wire       a_inbox;
    wire       a_outbox;
    wire       a_flags;
    wire       a_stin;
    wire       a_event;
    wire       a_mask;
    wire       a_stout;
    wire       a_hit;

    // Transfer completes in the answered access cycle
    assign apb_do = PSEL_I & PENABLE_I & PREADY_O;
    assign apb_wr = apb_do & PWRITE_I;
    assign apb_rd = apb_do & ~PWRITE_I;

    // One-hot register select; an unmapped address leaves it empty
    always @*
    begin
        dec = 7'h00;
        if (PADDR_I == `HMB_OFF_INBOX)
            dec = 7'h01;
        else if (PADDR_I == `HMB_OFF_OUTBOX)
            dec = 7'h02;
        else if (PADDR_I == `HMB_OFF_FLAGS)
            dec = 7'h04;
        else if (PADDR_I == `HMB_OFF_STATUS_IN)
            dec = 7'h08;
        else if (PADDR_I == `HMB_OFF_EVENT)
            dec = 7'h10;
        else if (PADDR_I == `HMB_OFF_MASK)
            dec = 7'h20;
        else if (PADDR_I == `HMB_OFF_STATUS_OUT)
            dec = 7'h40;
    end

    assign a_inbox  = dec[0];
    assign a_outbox = dec[1];
    assign a_flags  = dec[2];
    assign a_stin   = dec[3];
    assign a_event  = dec[4];
    assign a_mask   = dec[5];
    assign a_stout  = dec[6];
    assign a_hit    = |dec;

    // ==========================================================
    // Mailboxes and full flags
    reg [31:0] inbox;
    reg [31:0] outbox;
    reg        inbox_full;
    reg        outbox_full;

    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inbox       <= `HMB_RST_WORD;
            outbox      <= `HMB_RST_WORD;
            inbox_full  <= 1'b0; // R11
            outbox_full <= 1'b0; // R11
        end
        else
        begin
            if (host_wr)
                inbox <= data_s; // R5
            // Outbox word stays after a host read; only the flag drops
            if (apb_wr && a_outbox)
                outbox <= PWDATA_I;
            // Set wins over a clear in the same cycle
            if (host_wr)
                inbox_full <= 1'b1; // R1
            else if (apb_rd && a_inbox)
                inbox_full <= 1'b0; // R2
            if (apb_wr && a_outbox)
                outbox_full <= 1'b1; // R3
            else if (host_rd)
                outbox_full <= 1'b0; // R4
        end
    end

    // ==========================================================
    // Event, mask and status output registers
    reg  [`HMB_EV_W-1:0] event_bits;
    reg  [`HMB_EV_W-1:0] mask;
    reg  [3:0]           status_out;
    reg  [7:0]           init_cnt;
    wire [`HMB_EV_W-1:0] ev_set;
    wire [`HMB_EV_W-1:0] ev_clr;
    wire                 init_busy;

    assign ev_set = {status_s & ~status_d, host_rd, host_wr}; // R8
    assign ev_clr = (apb_wr && a_event) ? PWDATA_I[`HMB_EV_W-1:0] : {`HMB_EV_W{1'b0}};
    assign init_busy = (init_cnt != 8'h00);

    genvar g;
    generate
        for (g = 0; g < `HMB_EV_W; g = g + 1)
        begin : g_event
            always @(posedge CORE_CLK_I or negedge rst_n)
            begin
                if (!rst_n)
                    event_bits[g] <= 1'b0;
                else if (ev_set[g])
                    event_bits[g] <= 1'b1;
                else if (ev_clr[g])
                    event_bits[g] <= 1'b0;
            end
        end
    endgenerate

    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask       <= `HMB_RST_MASK;
            status_out <= `HMB_RST_STATUS_OUT;
        end
        else
        begin
            if (apb_wr && a_mask)
                mask <= PWDATA_I[`HMB_EV_W-1:0];
            if (apb_wr && a_stout)
                status_out <= PWDATA_I[3:0]; // R9
        end
    end

    // Init pattern hold-off, counted down once per reset
    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            init_cnt <= `HMB_INIT_CYCLES;
        else if (init_busy)
            init_cnt <= init_cnt - 8'h01; // R10
    end

    // ==========================================================
    // Registered outputs
    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (a_inbox)
            next_rdata = inbox;
        else if (a_outbox)
            next_rdata = outbox;
        else if (a_flags)
            next_rdata = {30'h0000_0000, outbox_full, inbox_full};
        else if (a_stin)
            next_rdata = {28'h000_0000, status_s}; // R7
        else if (a_event)
            next_rdata = {26'h000_0000, event_bits};
        else if (a_mask)
            next_rdata = {26'h000_0000, mask};
        else if (a_stout)
            next_rdata = {28'h000_0000, status_out};
    end

    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            // One wait state: answer in the second access cycle
            PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
            PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~a_hit;
            if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I)
                PRDATA_O <= next_rdata;
        end
    end

    // ==========================================================
    // Pin side outputs
    always @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            HOST_DATA_O        <= 32'h0000_0000;
            HOST_DATA_OE_O     <= 1'b0;
            INBOX_FULL_FLAG_O  <= 1'b0;
            OUTBOX_FULL_FLAG_O <= 1'b0;
            EXT_STATUS_OUT_O   <= `HMB_RST_STATUS_OUT; // R11
            IRQ_O              <= 1'b0;
        end
        else
        begin
            // Read data driven while the synced read request stands
            HOST_DATA_O        <= outbox;                      // R6
            HOST_DATA_OE_O     <= sel_s & rd_s & strobe_s;     // R6
            INBOX_FULL_FLAG_O  <= inbox_full;                  // R1
            OUTBOX_FULL_FLAG_O <= outbox_full;                 // R3
            EXT_STATUS_OUT_O   <= init_busy ? `HMB_INIT_PATTERN : status_out; // R10
            IRQ_O              <= |(event_bits & mask);
        end
    end
endmodule

/* rtl/hmb_defs.vh */
// Constants for the host mailbox and status pin block
`ifndef HMB_DEFS_VH
`define HMB_DEFS_VH

// ==========================================================
// Register byte offsets
`define HMB_ADDR_W          8
`define HMB_OFF_INBOX       8'h00
`define HMB_OFF_OUTBOX      8'h04
`define HMB_OFF_FLAGS       8'h08
`define HMB_OFF_STATUS_IN   8'h0C
`define HMB_OFF_EVENT       8'h10
`define HMB_OFF_MASK        8'h14
`define HMB_OFF_STATUS_OUT  8'h18

// ==========================================================
// Field positions
`define HMB_FLAG_INBOX_FULL   0
`define HMB_FLAG_OUTBOX_FULL  1
`define HMB_EV_HOST_WROTE     0
`define HMB_EV_HOST_READ      1
`define HMB_EV_STATUS_LSB     2
`define HMB_EV_W              6

// ==========================================================
// Reset values
`define HMB_RST_WORD        32'h0000_0000
`define HMB_RST_EVENT       6'h00
`define HMB_RST_MASK        6'h00
`define HMB_RST_STATUS_OUT  4'h0
`define HMB_INIT_PATTERN    4'hF

// ==========================================================
// Init count in core clock cycles and pin synchroniser width in bits
`define HMB_INIT_CYCLES     8'h10
`define HMB_SYNC_W          39

`endif

/* rtl/hmb_sync.v */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module hmb_sync
#(
    parameter WIDTH = 1
)
(
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta   <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end
        else
        begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

/* rtl/hmb_reset_sync.v */
// Reset release synchroniser: asserts at once, releases after two edges
`timescale 1ns/10ps
module hmb_reset_sync
(
    input  wire clk_i,
    input  wire nrst_i,
    output reg  rst_n_o
);
    reg stage;

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            stage   <= 1'b0;
            rst_n_o <= 1'b0;
        end
        else
        begin
            stage   <= 1'b1;
            rst_n_o <= stage;
        end
    end
endmodule

/* testbench/hmb_top_assertions.sv */
// Port checker for the host mailbox block
`timescale 1ns/10ps
module hmb_top_chk
(
    input wire       CORE_CLK_I,
    input wire       NRST_I,
    input wire       PSEL_I,
    input wire       PENABLE_I,
    input wire       PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire       PREADY_O,
    input wire       MAILBOX_SELECT_I,
    input wire       HOST_PORT_READ_SELECT_I,
    input wire       HOST_STROBE_I,
    input wire       HOST_DATA_OE_O,
    input wire       INBOX_FULL_FLAG_O,
    input wire       OUTBOX_FULL_FLAG_O,
    input wire [3:0] EXT_STATUS_OUT_O
);
    // =====
    // Host transfer starts
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    wire acc = PSEL_I && PENABLE_I && PREADY_O;
    sequence wr_go;
        $rose(HOST_STROBE_I) && MAILBOX_SELECT_I && !HOST_PORT_READ_SELECT_I;
    endsequence
    sequence rd_go;
        $rose(HOST_STROBE_I) && MAILBOX_SELECT_I && HOST_PORT_READ_SELECT_I;
    endsequence
    // =====
    // Assertions
    a_pready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not one wait state");
    a_inbox_set: assert property (wr_go |-> ##4 INBOX_FULL_FLAG_O)
        else $error("inbox flag not set");
    a_inbox_clear: assert property (acc && !PWRITE_I && PADDR_I == 8'h00 |-> ##2 !INBOX_FULL_FLAG_O)
        else $error("inbox flag not cleared");
    a_outbox_set: assert property (acc && PWRITE_I && PADDR_I == 8'h04 |-> ##2 OUTBOX_FULL_FLAG_O)
        else $error("outbox flag not set");
    a_outbox_clear: assert property (rd_go |-> ##4 !OUTBOX_FULL_FLAG_O)
        else $error("outbox flag not cleared");
    a_oe_read: assert property (rd_go |-> ##3 HOST_DATA_OE_O)
        else $error("read data not driven");
    a_oe_write: assert property (HOST_DATA_OE_O |-> $past(HOST_PORT_READ_SELECT_I, 3))
        else $error("data driven in write");
    a_init_pattern: assert property ($rose(NRST_I) |-> ##3 (EXT_STATUS_OUT_O == 4'hF)[*8])
        else $error("init pattern missing");
    a_reset_level: assert property (disable iff (1'b0) !NRST_I |->
        !INBOX_FULL_FLAG_O && !OUTBOX_FULL_FLAG_O && EXT_STATUS_OUT_O == 4'h0)
        else $error("outputs not at reset level");
endmodule
bind hmb_top hmb_top_chk u_chk
(
    .CORE_CLK_I              (CORE_CLK_I),
    .NRST_I                  (NRST_I),
    .PSEL_I                  (PSEL_I),
    .PENABLE_I               (PENABLE_I),
    .PWRITE_I                (PWRITE_I),
    .PADDR_I                 (PADDR_I),
    .PREADY_O                (PREADY_O),
    .MAILBOX_SELECT_I        (MAILBOX_SELECT_I),
    .HOST_PORT_READ_SELECT_I (HOST_PORT_READ_SELECT_I),
    .HOST_STROBE_I           (HOST_STROBE_I),
    .HOST_DATA_OE_O          (HOST_DATA_OE_O),
    .INBOX_FULL_FLAG_O       (INBOX_FULL_FLAG_O),
    .OUTBOX_FULL_FLAG_O      (OUTBOX_FULL_FLAG_O),
    .EXT_STATUS_OUT_O        (EXT_STATUS_OUT_O)
);

/* testbench/hmb_host_model.sv */
// Host model driving the mailbox pins
`timescale 1ns/10ps
module hmb_host
(
    input  wire         clk_i,
    input  wire         in_full_i,
    input  wire         out_full_i,
    input  wire         oe_i,
    input  wire  [31:0] data_i,
    output logic        sel_o = 1'b0,
    output logic        rd_o = 1'b0,
    output logic        stb_o = 1'b0,
    output logic [31:0] data_o = 32'h0000_0000
);
    // =====
    // One word per strobe
    task xfer(input logic r, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        while ((r ? out_full_i !== 1'b1 : in_full_i !== 1'b0) && n < 500)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 500)
        begin
            tb.num_errors++;
            $display("[ERR] %0t host flag wait timed out", $time);
        end
        @(posedge clk_i);
        sel_o <= 1'b1;
        rd_o <= r;
        data_o <= r ? ~data_o : d;
        repeat (3) @(posedge clk_i);
        stb_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        q = (oe_i === 1'b1) ? data_i : 32'hxxxx_xxxx;
        stb_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        sel_o <= 1'b0;
        data_o <= ~data_o;
    endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the host mailbox block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  sin = 4'h0;
    logic [31:0] prdata, hdi, hdo, q, hq;
    logic        pready, perr, sel, rd, stb, oe, inf, outf, irq, e;
    logic [3:0]  sout;
    int          num_errors = 0;
    int          n_compared = 0;

    always #2 clk = ~clk;
    hmb_top uut (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(perr),
        .MAILBOX_SELECT_I(sel), .HOST_PORT_READ_SELECT_I(rd), .HOST_STROBE_I(stb), .HOST_DATA_I(hdi),
        .HOST_DATA_O(hdo), .HOST_DATA_OE_O(oe), .INBOX_FULL_FLAG_O(inf), .OUTBOX_FULL_FLAG_O(outf),
        .EXT_STATUS_IN_I(sin), .EXT_STATUS_OUT_O(sout), .IRQ_O(irq));
    hmb_host u_host (.clk_i(clk), .in_full_i(inf), .out_full_i(outf), .oe_i(oe), .data_i(hdo),
        .sel_o(sel), .rd_o(rd), .stb_o(stb), .data_o(hdi));

    // =====
    // Bus tasks
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t bus answer timed out", $time);
        end
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(q, x);
    endtask
    task final_report;
        $display("Compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // =====
    // Tests
    initial
    begin
        #1 nrst = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(sout, 4'hF);
        repeat (20) @(posedge clk);
        `CHK(sout, 4'h0);
        rchk(8'h08, 32'h0000_0000);
        u_host.xfer(1'b0, 32'hA5C3_0F01, hq);
        `CHK(inf, 1'b1);
        rchk(8'h10, 32'h0000_0001);
        `CHK(irq, 1'b0);
        apb(1'b1, 8'h14, 32'h0000_003F);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1);
        apb(1'b1, 8'h10, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0);
        rchk(8'h00, 32'hA5C3_0F01);
        `CHK(inf, 1'b0);
        apb(1'b1, 8'h04, 32'h1234_5678);
        `CHK(outf, 1'b1);
        apb(1'b1, 8'h08, 32'h0000_0000);
        rchk(8'h08, 32'h0000_0002);
        u_host.xfer(1'b1, 32'h0000_0000, hq);
        `CHK(hq, 32'h1234_5678);
        `CHK(outf, 1'b0);
        rchk(8'h10, 32'h0000_0002);
        apb(1'b1, 8'h10, 32'h0000_003F);
        @(posedge clk);
        sin <= 4'h5;
        repeat (4) @(posedge clk);
        rchk(8'h0C, 32'h0000_0005);
        rchk(8'h10, 32'h0000_0014);
        `CHK(irq, 1'b1);
        apb(1'b1, 8'h18, 32'h0000_000A);
        rchk(8'h18, 32'h0000_000A);
        `CHK(e, 1'b0);
        `CHK(sout, 4'hA);
        rchk(8'h20, 32'h0000_0000);
        `CHK(e, 1'b1);
        final_report;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule
